// File: hw/sar_adc_pkg.sv
// Constants, field layouts and carrier types for the SAR converter sequencer.
// Assumes one 100 MHz clock and a 32-bit AXI4-Lite register port.
// Behaviour
// - Start bit begins one software-mode conversion
// - Mode codes: off, software, reserved, repeat
// - Start bit clears itself once conversion begins
// - Analog input disable bit gates inputs
// - Four-bit field selects one of sixteen inputs
// - No start for four cycles after zero write
// - Deep standby resets controls, blocks writes
// - Ladder connected during conversion or always
// - Time field picks conversion period count
// - Top two control-two bits read undefined
// - Completion stores result, sets flag, interrupts
// - Reading high result clears end flag
// - Busy set at start, cleared at end/standby
// - Low four result-low bits carry nothing
// - Repeat mode restarts after each completion
// - Disable code stops repeat, discards partial
// - New start clears end flag, keeps result
package sar_adc_pkg;

   // Register word indices, byte address is four times these
   localparam logic [7:0] IDX_CONTROL_ONE = 8'h26;
   localparam logic [7:0] IDX_CONTROL_TWO = 8'h27;
   localparam logic [7:0] IDX_RESULT_LOW  = 8'h28;
   localparam logic [7:0] IDX_RESULT_HIGH = 8'h29;

   // Reset values and the control one zero-write value
   localparam logic [7:0] CONTROL_ONE_RESET = 8'h10;
   localparam logic [7:0] CONTROL_TWO_RESET = 8'h10;
   localparam logic [7:0] CONTROL_ONE_ZERO  = 8'h00;

   // Field positions in control one
   localparam int START_BIT   = 7;
   localparam int MODE_HI     = 6;
   localparam int MODE_LO     = 5;
   localparam int AIN_DIS_BIT = 4;
   localparam int CHAN_HI     = 3;
   // Field positions in control two
   localparam int LADDER_BIT  = 5;
   localparam int TIME_HI     = 3;
   localparam int TIME_LO     = 1;

   // Operating mode codes
   typedef enum logic [1:0] {
      MODE_OFF    = 2'b00,
      MODE_SOFT   = 2'b01,
      MODE_RSVD   = 2'b10,
      MODE_REPEAT = 2'b11
   } op_mode_type;

   // Sequencer states
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_CONV = 2'b01
   } seq_state_type;

   // Lockout after control one written with zero, in clock cycles
   localparam logic [2:0] LOCKOUT_CYCLES = 3'h4;

   // Clock rate and conversion period counts in high-frequency clock periods
   localparam int CLOCK_HZ = 100_000_000;
   localparam logic [10:0] PERIODS_39   = 11'h027;
   localparam logic [10:0] PERIODS_78   = 11'h04e;
   localparam logic [10:0] PERIODS_156  = 11'h09c;
   localparam logic [10:0] PERIODS_312  = 11'h138;
   localparam logic [10:0] PERIODS_624  = 11'h270;
   localparam logic [10:0] PERIODS_1248 = 11'h4e0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Register write and read strobe carrier
   typedef struct packed {
      logic       wrOne;
      logic       wrTwo;
      logic       rdHigh;
      logic [7:0] data;
   } reg_access_type;

   // Conversion status carrier
   typedef struct packed {
      logic       busy;
      logic       endFlag;
      logic [9:0] result;
   } conv_status_type;

endpackage : sar_adc_pkg

// File: hw/conv_timer.sv
// Conversion period counter with a decoder of the time field.
// Assumes start and abort come from logic on the same clock.
`timescale 1ns/1ns
module conv_timer
   import sar_adc_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       reset_n,
   // Control
   input  wire logic       start,
   input  wire logic       abort,
   input  wire logic [2:0] timeSel,
   // Status
   output logic            done
);

   logic [10:0] count_reg;   // Periods elapsed
   logic [10:0] limit_reg;   // Periods latched at start
   logic        run_reg;     // Counting

   // Decode time code to a period count, reserved codes use longest
   function automatic logic [10:0] periodsOf(input logic [2:0] code);
      case (code)
         3'h0:    periodsOf = PERIODS_39;
         3'h2:    periodsOf = PERIODS_78;
         3'h3:    periodsOf = PERIODS_156;
         3'h4:    periodsOf = PERIODS_312;
         3'h5:    periodsOf = PERIODS_624;
         default: periodsOf = PERIODS_1248;
      endcase
   endfunction : periodsOf

   // Counter, latched limit keeps a mid-run field change harmless
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= 11'h000;
         limit_reg <= PERIODS_1248;
         run_reg   <= 1'b0;
         done      <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            run_reg <= 1'b0;
         end else if (start) begin
            count_reg <= 11'h001;
            limit_reg <= periodsOf(timeSel);
            run_reg   <= 1'b1;
         end else if (run_reg) begin
            if (count_reg == limit_reg) begin
               run_reg <= 1'b0;
               done    <= 1'b1;
            end else begin
               count_reg <= count_reg + 11'h001;
            end
         end
      end
   end

endmodule : conv_timer

// File: hw/axil_byte_regs.sv
// AXI4-Lite slave front end producing byte register strobes.
// Assumes a master with at most one read and one write under way.
`timescale 1ns/1ns
module axil_byte_regs
   import sar_adc_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // Write channels
   input  wire logic [9:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // Read channels
   input  wire logic [9:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Register side
   input  wire logic [7:0]  rdOne,
   input  wire logic [7:0]  rdTwo,
   input  wire logic [7:0]  rdLow,
   input  wire logic [7:0]  rdHigh,
   output reg_access_type   access
);

   logic [9:0] awAddr_reg;  // Captured write address
   logic       awHave_reg;  // Address held
   logic [7:0] wData_reg;   // Captured low byte
   logic       wLane_reg;   // Low lane enabled
   logic       wHave_reg;   // Data held

   // Word index of a byte address, the two low bits are ignored
   function automatic logic [7:0] wordIdx(input logic [9:0] a);
      wordIdx = a[9:2];
   endfunction : wordIdx

   assign awready = !awHave_reg && !bvalid;
   assign wready  = !wHave_reg && !bvalid;
   assign arready = !rvalid;

   // Write capture and response, either channel first; this process owns every strobe
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         awAddr_reg <= 10'h000;
         awHave_reg <= 1'b0;
         wData_reg  <= 8'h00;
         wLane_reg  <= 1'b0;
         wHave_reg  <= 1'b0;
         bvalid     <= 1'b0;
         bresp      <= RESP_OKAY;
         access.wrOne <= 1'b0;
         access.wrTwo <= 1'b0;
         access.data  <= 8'h00;
         access.rdHigh <= 1'b0;
      end else begin
         access.wrOne <= 1'b0;
         access.wrTwo <= 1'b0;
         // High result read pulse, one cycle, in the cycle after the read address is taken
         access.rdHigh <= arvalid && arready && wordIdx(araddr) == IDX_RESULT_HIGH;
         if (awvalid && awready) begin
            awAddr_reg <= awaddr;
            awHave_reg <= 1'b1;
         end
         if (wvalid && wready) begin
            wData_reg <= wdata[7:0];
            wLane_reg <= wstrb[0];
            wHave_reg <= 1'b1;
         end
         if (awHave_reg && wHave_reg) begin
            awHave_reg  <= 1'b0;
            wHave_reg   <= 1'b0;
            bvalid      <= 1'b1;
            access.data <= wData_reg;
            if (wordIdx(awAddr_reg) == IDX_CONTROL_ONE) begin
               access.wrOne <= wLane_reg;
               bresp        <= RESP_OKAY;
            end else if (wordIdx(awAddr_reg) == IDX_CONTROL_TWO) begin
               access.wrTwo <= wLane_reg;
               bresp        <= RESP_OKAY;
            end else if (wordIdx(awAddr_reg) == IDX_RESULT_LOW
                         || wordIdx(awAddr_reg) == IDX_RESULT_HIGH) begin
               bresp <= RESP_OKAY;  // Read-only, write ignored
            end else begin
               bresp <= RESP_SLVERR;
            end
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Read path, one cycle to answer
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rvalid        <= 1'b0;
         rdata         <= 32'h0000_0000;
         rresp         <= RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= RESP_OKAY;
            rdata  <= 32'h0000_0000;
            if (wordIdx(araddr) == IDX_CONTROL_ONE) begin
               rdata[7:0] <= rdOne;
            end else if (wordIdx(araddr) == IDX_CONTROL_TWO) begin
               rdata[7:0] <= rdTwo;
            end else if (wordIdx(araddr) == IDX_RESULT_LOW) begin
               rdata[7:0] <= rdLow;
            end else if (wordIdx(araddr) == IDX_RESULT_HIGH) begin
               rdata[7:0]    <= rdHigh;
            end else begin
               rresp <= RESP_SLVERR;
            end
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

endmodule : axil_byte_regs

// File: hw/sar_adc_sequencer.sv
// Top of the SAR converter sequencer: control registers, start logic,
// repeat sequencing, result capture and status flags.
// Assumes the analog sample-hold and comparator deliver a 10-bit code
// that is valid in the cycle the conversion period ends.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
module sar_adc_sequencer
   import sar_adc_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // AXI4-Lite write
   input  wire logic [9:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [9:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Power state
   input  wire logic        deepStandby,
   // Analog side
   input  wire logic [9:0]  analogCode,
   output logic [3:0]       channelSel,
   output logic             analogInputOff,
   output logic             ladderOn,
   output logic             sampleRun,
   // Event
   output logic             conv_done_irq
);

   reg_access_type  access;          // Register strobes
   conv_status_type status_reg;      // Busy, end flag, result
   seq_state_type   state_reg;       // Sequencer state
   logic [7:0]      ctrlOne_reg;     // Control one
   logic [7:0]      ctrlTwo_reg;     // Control two
   logic [2:0]      lockout_reg;     // Start lockout countdown
   logic            startPend_reg;   // Start request waiting
   logic [2:0]      sbySync_reg;     // Standby pin synchroniser
   logic            standby_reg;     // Filtered standby level
   logic            timerStart;      // Begin a period
   logic            timerAbort;      // Drop a period
   logic            timerDone;       // Period ended
   logic [7:0]      rdLow;           // Low result view
   logic [7:0]      rdTwoView;       // Control two view
   op_mode_type     mode;            // Decoded mode

   assign mode = op_mode_type'(ctrlOne_reg[MODE_HI:MODE_LO]);

   // Three-stage synchroniser; second and third must agree
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sbySync_reg <= 3'h0;
         standby_reg <= 1'b0;
      end else begin
         sbySync_reg <= {sbySync_reg[1:0], deepStandby};
         if (sbySync_reg[1] == sbySync_reg[2]) begin
            standby_reg <= sbySync_reg[2];
         end
      end
   end

   // Bus front end
   axil_byte_regs u_bus (
      .mclk    (mclk),
      .reset_n (reset_n),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .rdOne   (ctrlOne_reg),
      .rdTwo   (rdTwoView),
      .rdLow   (rdLow),
      .rdHigh  (status_reg.result[9:2]),
      .access  (access)
   );

   // Top two bits of control two are undefined; they read as zero here
   assign rdTwoView = {2'b00, ctrlTwo_reg[5:0]};

   // Result low bits, flags, and nothing defined below
   assign rdLow = {status_reg.result[1:0], status_reg.endFlag,
                   status_reg.busy, 4'h0};

   // Control one: writes, self-clearing start, standby init
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlOne_reg <= CONTROL_ONE_RESET;
      end else if (standby_reg) begin
         ctrlOne_reg <= CONTROL_ONE_RESET;
      end else if (access.wrOne) begin
         ctrlOne_reg <= access.data;
      end else if (timerStart) begin
         ctrlOne_reg[START_BIT] <= 1'b0;
      end
   end

   // Control two: standby init, writes
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlTwo_reg <= CONTROL_TWO_RESET;
      end else if (standby_reg) begin
         ctrlTwo_reg <= CONTROL_TWO_RESET;
      end else if (access.wrTwo) begin
         ctrlTwo_reg <= access.data;
      end
   end

   // Lockout after a zero write to control one
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lockout_reg <= 3'h0;
      end else if (access.wrOne && access.data == CONTROL_ONE_ZERO) begin
         lockout_reg <= LOCKOUT_CYCLES;
      end else if (lockout_reg != 3'h0) begin
         lockout_reg <= lockout_reg - 3'h1;
      end
   end

   // A start request sits in the start bit; it acts once lockout ends
   always_comb begin
      startPend_reg = ctrlOne_reg[START_BIT] && lockout_reg == 3'h0
                      && !standby_reg && state_reg == SEQ_IDLE
                      && (mode == MODE_SOFT || mode == MODE_REPEAT);
   end

   // Repeat restarts on completion; otherwise start from the bit
   assign timerStart = startPend_reg
                       || (state_reg == SEQ_CONV && timerDone
                           && mode == MODE_REPEAT && !standby_reg);
   // Disable or standby drop a running period at once
   assign timerAbort = state_reg == SEQ_CONV
                       && (mode == MODE_OFF || standby_reg);

   // Period counter
   conv_timer u_timer (
      .mclk    (mclk),
      .reset_n (reset_n),
      .start   (timerStart),
      .abort   (timerAbort),
      .timeSel (ctrlTwo_reg[TIME_HI:TIME_LO]),
      .done    (timerDone)
   );

   // Sequencer state
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= SEQ_IDLE;
      end else begin
         case (state_reg)
            SEQ_IDLE: begin
               if (timerStart) begin
                  state_reg <= SEQ_CONV;
               end
            end
            SEQ_CONV: begin
               if (timerAbort) begin
                  state_reg <= SEQ_IDLE;
               end else if (timerDone && !timerStart) begin
                  state_reg <= SEQ_IDLE;
               end
            end
            default: state_reg <= SEQ_IDLE;
         endcase
      end
   end

   // Status: result, end flag and busy share one struct, so one process owns it
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         status_reg.result  <= 10'h000;
         status_reg.endFlag <= 1'b0;
         status_reg.busy    <= 1'b0;
      end else if (standby_reg) begin
         status_reg.result  <= 10'h000;
         status_reg.endFlag <= 1'b0;
         status_reg.busy    <= 1'b0;
      end else begin
         // Result only on a completed period; completion wins over a read or a restart
         if (state_reg == SEQ_CONV && timerDone && !timerAbort) begin
            status_reg.result  <= analogCode;
            status_reg.endFlag <= 1'b1;
         end else if (access.rdHigh || startPend_reg) begin
            status_reg.endFlag <= 1'b0;
         end
         // Busy; a repeat restart keeps it set
         if (timerAbort) begin
            status_reg.busy <= 1'b0;
         end else if (timerStart) begin
            status_reg.busy <= 1'b1;
         end else if (timerDone) begin
            status_reg.busy <= 1'b0;
         end
      end
   end

   // Completion pulse, same edge as result and flag
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         conv_done_irq <= 1'b0;
      end else begin
         conv_done_irq <= state_reg == SEQ_CONV && timerDone
                          && !timerAbort && !standby_reg;
      end
   end

   // Analog side controls, registered
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         channelSel     <= 4'h0;
         analogInputOff <= 1'b1;
         ladderOn       <= 1'b0;
         sampleRun      <= 1'b0;
      end else begin
         channelSel     <= ctrlOne_reg[CHAN_HI:0];
         analogInputOff <= ctrlOne_reg[AIN_DIS_BIT];
         // Ladder follows conversion unless held on; off in standby
         ladderOn       <= !standby_reg
                           && (ctrlTwo_reg[LADDER_BIT] || status_reg.busy);
         sampleRun      <= status_reg.busy;
      end
   end

endmodule : sar_adc_sequencer

// File: verif/sar_adc_checker.sv
// Port-level checks for the converter sequencer.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ns
module sar_adc_checker
   import sar_adc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Bus handshakes
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   // Converter side
   input wire logic deepStandby,
   input wire logic analogInputOff,
   input wire logic ladderOn,
   input wire logic sampleRun,
   input wire logic conv_done_irq
);
   logic [10:0] runCnt;  // Run cycles since last completion
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // Saturating so a stuck run cannot wrap back to small counts
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) runCnt <= 11'h000;
      else if (conv_done_irq) runCnt <= 11'h000;
      else if (sampleRun && runCnt != 11'h7ff) runCnt <= runCnt + 11'h001;
   end
   sequence s_wr_taken; awvalid && awready && wvalid && wready; endsequence
   sequence s_rd_taken; arvalid && arready; endsequence
   sequence s_standby; deepStandby [*8]; endsequence
   property p_irq_pulse; conv_done_irq |=> !conv_done_irq; endproperty
   property p_irq_after_run; conv_done_irq |-> runCnt >= 11'h023; endproperty
   property p_ladder_run; $rose(sampleRun) |-> ladderOn; endproperty
   property p_standby_quiet; s_standby |=> !sampleRun && analogInputOff && !conv_done_irq; endproperty
   property p_write_answer; s_wr_taken |-> ##2 bvalid; endproperty
   property p_read_answer; s_rd_taken |=> rvalid; endproperty
   property p_refuse; bvalid |-> !awready && !wready; endproperty
   property p_rvalid_cause; $rose(rvalid) |-> $past(arvalid && arready); endproperty
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("completion pulse too long");
   a_irq_after_run: assert property (p_irq_after_run)
      else $error("completion came too early");
   a_ladder_run: assert property (p_ladder_run)
      else $error("ladder off while converting");
   a_standby_quiet: assert property (p_standby_quiet)
      else $error("activity in deep standby");
   a_write_answer: assert property (p_write_answer)
      else $error("write response missing");
   a_read_answer: assert property (p_read_answer)
      else $error("read data missing");
   a_refuse: assert property (p_refuse)
      else $error("ready while response held");
   a_rvalid_cause: assert property (p_rvalid_cause)
      else $error("read data without request");
endmodule : sar_adc_checker
bind sar_adc_sequencer sar_adc_checker chk_i (.mclk, .reset_n, .awvalid, .awready, .wvalid, .wready,
   .bvalid, .arvalid, .arready, .rvalid, .deepStandby, .analogInputOff, .ladderOn, .sampleRun, .conv_done_irq);

// File: verif/analog_front_model.sv
// Sample-hold and comparator stand-in for the converter.
// Assumes the code is taken while sampleRun is high.
`timescale 1ns/1ns
module analog_front_model
   import sar_adc_pkg::*;
(
   // Clock and reset
   input wire logic       mclk,
   input wire logic       reset_n,
   // From the sequencer
   input wire logic [3:0] channelSel,
   input wire logic       sampleRun,
   input wire logic       conv_done_irq,
   // Code to the sequencer
   output logic [9:0]     analogCode
);
   logic [5:0] nConv;    // Completed conversions
   logic [9:0] idlePat;  // Toggling junk outside sampling
   // Code changes per conversion so a stale capture shows
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) nConv <= 6'h00;
      else if (conv_done_irq) nConv <= nConv + 6'h01;
   end
   // Idle code flips every cycle so nothing settles by luck
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) idlePat <= 10'h155;
      else idlePat <= ~idlePat;
   end
   assign analogCode = sampleRun ? {channelSel, nConv} : idlePat;
endmodule : analog_front_model

// File: verif/tb.sv
// Register-level bench for the converter sequencer.
// Assumes the analog model returns {channel, conversion count}.
`timescale 1ns/1ns
module tb;
   import sar_adc_pkg::*;
   localparam logic [9:0] A1 = {IDX_CONTROL_ONE, 2'h0};
   localparam logic [9:0] A2 = {IDX_CONTROL_TWO, 2'h0};
   localparam logic [9:0] AL = {IDX_RESULT_LOW, 2'h0};
   localparam logic [9:0] AH = {IDX_RESULT_HIGH, 2'h0};
   logic mclk = 1'h0, reset_n = 1'h0, deepStandby = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [9:0] awaddr = 10'h000, araddr = 10'h000, analogCode, res = 10'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h1, channelSel, ch;
   logic awready, wready, bvalid, arready, rvalid, analogInputOff, ladderOn, sampleRun, conv_done_irq;
   logic [1:0] bresp, rresp, rs;
   logic [7:0] rd;
   int badCount = 0, nTests = 0, nDone = 0, c, k, i;
   time t0;
   logic [2:0] codes [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
   int per [6] = '{39, 78, 156, 312, 624, 1248};
   sar_adc_sequencer uut (.mclk(mclk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .deepStandby(deepStandby),
      .analogCode(analogCode), .channelSel(channelSel), .analogInputOff(analogInputOff),
      .ladderOn(ladderOn), .sampleRun(sampleRun), .conv_done_irq(conv_done_irq));
   analog_front_model model (.mclk(mclk), .reset_n(reset_n), .channelSel(channelSel),
      .sampleRun(sampleRun), .conv_done_irq(conv_done_irq), .analogCode(analogCode));
   always #5 mclk = ~mclk;
   // Completions seen, mirrors the model's count
   always @(posedge mclk) if (conv_done_irq === 1'h1) nDone <= nDone + 1;
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      nTests++;
      if (g !== e) begin
         badCount++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task summarize();
      $display("comparisons %0d mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // One bus transfer; handshakes judged at the negedge before each edge
   task automatic xfer(input bit w, input logic [9:0] a, input logic [7:0] d);
      logic aT, wT, arT, dn;
      @(posedge mclk);
      if (w) begin
         awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
      end else begin
         araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
      end
      dn = 1'h0;
      for (int t = 0; t < 100 && !dn; t++) begin
         @(negedge mclk);
         aT = awvalid & awready; wT = wvalid & wready; arT = arvalid & arready;
         dn = w ? bvalid : rvalid; rd = rdata[7:0]; rs = w ? bresp : rresp;
         @(posedge mclk);
         if (aT) awvalid <= 1'h0;
         if (wT) wvalid <= 1'h0;
         if (arT) arvalid <= 1'h0;
         if (dn) begin bready <= 1'h0; rready <= 1'h0; end
      end
      chk("answer", 8'h01, 8'(dn));
   endtask : xfer
   task wr(input logic [9:0] a, input logic [7:0] d);
      xfer(1'h1, a, d);
      chk("bresp", 8'(RESP_OKAY), 8'(rs));
   endtask : wr
   task rdChk(input logic [9:0] a, input logic [7:0] e, input string nm);
      xfer(1'h0, a, 8'h00);
      chk(nm, e, rd);
   endtask : rdChk
   // Bounded wait for the completion pulse, c holds cycles waited
   task waitIrq();
      c = 0;
      do begin @(posedge mclk); #1; c++; end while (conv_done_irq !== 1'h1 && c < 1500);
      chk("irq", 8'h01, 8'(conv_done_irq));
   endtask : waitIrq
   initial begin
      repeat (20000) @(posedge mclk);
      badCount++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge mclk);
      reset_n <= 1'h1;
      rdChk(A1, CONTROL_ONE_RESET, "ctl1");
      rdChk(AL, 8'h00, "low");
      rdChk(AH, 8'h00, "high");
      chk("ainoff", 8'h01, 8'(analogInputOff));
      xfer(1'h0, 10'h3fc, 8'h00);
      chk("slverr", 8'(RESP_SLVERR), 8'(rs));
      $display("reset test done");
      // Time codes 0 and 2 to 6, channels 0 to 15 in steps of 3
      for (i = 0; i < 6; i++) begin
         ch = 4'(i * 3);
         wr(A2, {3'h0 | 3'(i % 2), 1'h1, codes[i], 1'h0});
         wr(A1, {1'h1, MODE_SOFT, 1'h0, ch});
         t0 = $time;
         rdChk(A1, {1'h0, MODE_SOFT, 1'h0, ch}, "ctl1");
         rdChk(AL, {res[1:0], 6'h10}, "busylow");
         chk("chan", 8'(ch), 8'(channelSel));
         chk("ainon", 8'h00, 8'(analogInputOff));
         chk("ladder", 8'h01, 8'(ladderOn));
         waitIrq();
         c = int'(($time - t0) / 10);
         res = {ch, 6'(nDone)};
         chk("cycles", 8'h01, 8'(c >= per[i] - 3 && c <= per[i] + 3));
         rdChk(AL, {res[1:0], 6'h20}, "endlow");
         rdChk(AH, res[9:2], "high");
         rdChk(AL, {res[1:0], 6'h00}, "clrlow");
         chk("ladderidle", 8'(i % 2), 8'(ladderOn));
      end
      $display("software test done");
      for (i = 0; i < 2; i++) begin
         wr(A1, {1'h1, i ? MODE_RSVD : MODE_OFF, 5'h01});
         repeat (3) @(posedge mclk);
         rdChk(AL, {res[1:0], 6'h00}, "nostart");
      end
      wr(A1, CONTROL_ONE_ZERO);
      repeat (6) @(posedge mclk);
      wr(A2, 8'h10);
      wr(A1, {1'h1, MODE_REPEAT, 5'h05});
      waitIrq();
      waitIrq();
      chk("restart", 8'h01, 8'(c <= 42));
      res = {4'h5, 6'(nDone)};
      rdChk(AH, res[9:2], "rephigh");
      rdChk(AL, {res[1:0], 6'h10}, "repbusy");
      wr(A1, CONTROL_ONE_ZERO);
      k = nDone;
      repeat (60) @(posedge mclk);
      chk("aborted", 8'(k), 8'(nDone));
      rdChk(AH, res[9:2], "abhigh");
      xfer(1'h0, AL, 8'h00);
      chk("abbusy", 8'h00, 8'(rd[4]));
      $display("repeat test done");
      wr(A1, {1'h1, MODE_SOFT, 5'h02});
      repeat (4) @(posedge mclk);
      deepStandby <= 1'h1;
      repeat (10) @(posedge mclk);
      #1 chk("sbrun", 8'h00, 8'(sampleRun));
      rdChk(A1, CONTROL_ONE_RESET, "sbctl1");
      wr(A1, 8'ha5);
      rdChk(A1, CONTROL_ONE_RESET, "sbwrite");
      rdChk(A2, CONTROL_TWO_RESET, "sbctl2");
      deepStandby <= 1'h0;
      $display("standby test done");
      summarize();
   end
endmodule : tb
